// file: pkg/lpsc_pkg.sv
package lpsc_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned REG_W = 16;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_TOP_CONFIG = 10'h181;
  localparam logic [IDX_W-1:0] IDX_STATE_OVERRIDE = 10'h183;
  localparam logic [IDX_W-1:0] IDX_LP_CONFIG_TWO = 10'h18B;
  localparam logic [IDX_W-1:0] IDX_MODE_COMMAND = 10'h18C;
  localparam logic [IDX_W-1:0] IDX_STATE_STATUS = 10'h18E;

  // ==========================================================
  // Field positions
  localparam int unsigned MAC_PD_EN_BIT = 10;
  localparam int unsigned OVR_EN_BIT = 7;
  localparam int unsigned OVR_VAL_MSB = 6;
  localparam int unsigned LINE_ENERGY_DETECT_ENABLE_BIT = 8;
  localparam int unsigned SLEEP_EN_BIT = 7;
  localparam int unsigned AUTO_MODE_BIT = 6;
  localparam int unsigned CMD_STANDBY_BIT = 4;
  localparam int unsigned CMD_NORMAL_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [REG_W-1:0] TOP_CONFIG_RST = 16'h0400;
  localparam logic [REG_W-1:0] STATE_OVERRIDE_RST = 16'h0000;
  localparam logic [REG_W-1:0] LP_CONFIG_TWO_RST = 16'h0000;
  localparam logic [REG_W-1:0] MODE_COMMAND_RST = 16'h0000;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Power states, encoded as reported in the status field
  typedef enum logic [6:0] {
    ST_INIT = 7'h00,
    ST_STANDBY = 7'h02,
    ST_NORMAL = 7'h04,
    ST_SLEEP = 7'h06
  } lpsc_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } lpsc_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lpsc_axil_rsp_t;

  // Word-aligned address to register index
  function automatic logic [IDX_W-1:0] addrToIdx(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = addrToIdx(addr);
    return (addr[1:0] == 2'h0) && (idx == IDX_TOP_CONFIG || idx == IDX_STATE_OVERRIDE ||
           idx == IDX_LP_CONFIG_TWO || idx == IDX_MODE_COMMAND || idx == IDX_STATE_STATUS);
  endfunction

endpackage

// file: design/lpsc_axil_slave.sv
`timescale 1ns/1ps
module lpsc_axil_slave (
  input wire logic clk,
  input wire logic rst,
  input wire lpsc_pkg::lpsc_axil_req_t axiReq,
  output lpsc_pkg::lpsc_axil_rsp_t axiRsp,
  output logic wrEn,
  output logic [lpsc_pkg::IDX_W-1:0] wrIdx,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  output logic [lpsc_pkg::IDX_W-1:0] rdIdx,
  input wire logic [31:0] rdData
);

  logic awHave_q;
  logic wHave_q;
  logic [lpsc_pkg::ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bValid_q;
  logic [1:0] bResp_q;
  logic rValid_q;
  logic [31:0] rData_q;
  logic [1:0] rResp_q;
  logic awFire;
  logic wFire;
  logic arFire;
  logic doWrite;

  // ==========================================================
  // Handshakes
  assign awFire = axiReq.awvalid && !awHave_q && !bValid_q;
  assign wFire = axiReq.wvalid && !wHave_q && !bValid_q;
  assign arFire = axiReq.arvalid && !rValid_q;
  assign doWrite = awHave_q && wHave_q;

  assign wrEn = doWrite && lpsc_pkg::isMapped(awAddr_q);
  assign wrIdx = lpsc_pkg::addrToIdx(awAddr_q);
  assign wrData = wData_q;
  assign wrStrb = wStrb_q;
  assign rdIdx = lpsc_pkg::addrToIdx(axiReq.araddr);

  always_comb begin
    axiRsp.awready = !awHave_q && !bValid_q;
    axiRsp.wready = !wHave_q && !bValid_q;
    axiRsp.bvalid = bValid_q;
    axiRsp.bresp = bResp_q;
    axiRsp.arready = !rValid_q;
    axiRsp.rvalid = rValid_q;
    axiRsp.rdata = rData_q;
    axiRsp.rresp = rResp_q;
  end

  // ==========================================================
  // Write path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else begin
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
      end else begin
        if (awFire) begin
          awHave_q <= 1'b1;
          awAddr_q <= axiReq.awaddr;
        end
        if (wFire) begin
          wHave_q <= 1'b1;
          wData_q <= axiReq.wdata;
          wStrb_q <= axiReq.wstrb;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bValid_q <= 1'b0;
      bResp_q <= lpsc_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'b1;
      bResp_q <= lpsc_pkg::isMapped(awAddr_q) ? lpsc_pkg::RESP_OKAY : lpsc_pkg::RESP_SLVERR;
    end else if (bValid_q && axiReq.bready) begin
      bValid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Read path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rValid_q <= 1'b0;
      rData_q <= 32'h0000_0000;
      rResp_q <= lpsc_pkg::RESP_OKAY;
    end else if (arFire) begin
      rValid_q <= 1'b1;
      rData_q <= lpsc_pkg::isMapped(axiReq.araddr) ? rdData : 32'h0000_0000;
      rResp_q <= lpsc_pkg::isMapped(axiReq.araddr) ? lpsc_pkg::RESP_OKAY : lpsc_pkg::RESP_SLVERR;
    end else if (rValid_q && axiReq.rready) begin
      rValid_q <= 1'b0;
    end
  end

endmodule

// file: design/lpsc_top.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
// Function
// - Override enable bit 7 holds the state machine in the state given by bits 6-0.
// - Config-two bit 8 turns line energy detection on or off.
// - Config-two bit 7 must be 1 for entry into sleep, except when the override forces it.
// - Autonomous bit 6 picks power-up state: 1 normal, 0 standby.
// - Command bit 4 requests standby and clears itself once taken.
// - Command bit 0 requests normal and clears itself once taken.
// - Status bits 6-0 show the current state: 0x2 standby, 0x4 normal.
// - Enable bit 10, reset 1, powers down the MAC interface in low power.
module lpsc_top (
  input wire logic clk,
  input wire logic rst,
  input wire lpsc_pkg::lpsc_axil_req_t axiReq,
  output lpsc_pkg::lpsc_axil_rsp_t axiRsp,
  input wire logic autoModeStrap,
  input wire logic sleepRequest,
  input wire logic lineEnergyDetected,
  input wire logic localWakeRequest,
  output logic lineEnergyDetectEnable,
  output logic macInterfacePowerDown,
  output logic [6:0] currentPowerState
);

  logic wrEn;
  logic [lpsc_pkg::IDX_W-1:0] wrIdx;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic [lpsc_pkg::IDX_W-1:0] rdIdx;
  logic [31:0] rdData;

  logic [lpsc_pkg::REG_W-1:0] topConfig_q;
  logic [lpsc_pkg::REG_W-1:0] stateOverride_q;
  logic [lpsc_pkg::REG_W-1:0] lpConfigTwo_q;
  logic standbyCmd_q;
  logic normalCmd_q;
  logic strapTaken_q;
  logic macPowerDown_q;
  lpsc_pkg::lpsc_state_t state_q;
  lpsc_pkg::lpsc_state_t state_d;

  logic overrideStateEnable;
  logic [6:0] overrideStateValue;
  logic sleepAllowed;
  logic autoMode;
  logic cmdTaken;
  logic wakeEvent;
  logic [15:0] topMerged;
  logic [15:0] overrideMerged;
  logic [15:0] configTwoMerged;

  // Merge the enabled byte lanes of a write into a 16-bit register
  function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  function automatic logic hits(input logic en, input logic [lpsc_pkg::IDX_W-1:0] idx,
                                input logic [lpsc_pkg::IDX_W-1:0] target);
    return en && (idx == target);
  endfunction

  // ==========================================================
  // Bus slave
  lpsc_axil_slave u_slave (
    .clk(clk),
    .rst(rst),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .wrEn(wrEn),
    .wrIdx(wrIdx),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .rdIdx(rdIdx),
    .rdData(rdData)
  );

  // ==========================================================
  // Field views
  assign overrideStateEnable = stateOverride_q[lpsc_pkg::OVR_EN_BIT];
  assign overrideStateValue = stateOverride_q[lpsc_pkg::OVR_VAL_MSB:0];
  assign topMerged = mergeLanes(topConfig_q, wrData, wrStrb);
  assign overrideMerged = mergeLanes(stateOverride_q, wrData, wrStrb);
  assign configTwoMerged = mergeLanes(lpConfigTwo_q, wrData, wrStrb);
  assign sleepAllowed = lpConfigTwo_q[lpsc_pkg::SLEEP_EN_BIT];
  assign autoMode = lpConfigTwo_q[lpsc_pkg::AUTO_MODE_BIT];
  assign wakeEvent = (lineEnergyDetected && lpConfigTwo_q[lpsc_pkg::LINE_ENERGY_DETECT_ENABLE_BIT]) || localWakeRequest;
  // Commands are consumed only while the machine runs on its own
  assign cmdTaken = !overrideStateEnable && state_q != lpsc_pkg::ST_INIT;

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      topConfig_q <= lpsc_pkg::TOP_CONFIG_RST;
    end else if (hits(wrEn, wrIdx, lpsc_pkg::IDX_TOP_CONFIG)) begin
      topConfig_q[lpsc_pkg::MAC_PD_EN_BIT] <= topMerged[lpsc_pkg::MAC_PD_EN_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stateOverride_q <= lpsc_pkg::STATE_OVERRIDE_RST;
    end else if (hits(wrEn, wrIdx, lpsc_pkg::IDX_STATE_OVERRIDE)) begin
      stateOverride_q[7:0] <= overrideMerged[7:0];
    end
  end

  // Autonomous bit is loaded from the strap once after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lpConfigTwo_q <= lpsc_pkg::LP_CONFIG_TWO_RST;
      strapTaken_q <= 1'b0;
    end else begin
      strapTaken_q <= 1'b1;
      if (!strapTaken_q) begin
        lpConfigTwo_q[lpsc_pkg::AUTO_MODE_BIT] <= autoModeStrap;
      end else if (hits(wrEn, wrIdx, lpsc_pkg::IDX_LP_CONFIG_TWO)) begin
        lpConfigTwo_q[8:0] <= configTwoMerged[8:0];
      end
    end
  end

  // ==========================================================
  // Self-clearing commands; a write in the taking cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      standbyCmd_q <= 1'b0;
      normalCmd_q <= 1'b0;
    end else if (hits(wrEn, wrIdx, lpsc_pkg::IDX_MODE_COMMAND) && wrStrb[0]) begin
      standbyCmd_q <= wrData[lpsc_pkg::CMD_STANDBY_BIT] || (standbyCmd_q && !cmdTaken);
      normalCmd_q <= wrData[lpsc_pkg::CMD_NORMAL_BIT] || (normalCmd_q && !cmdTaken);
    end else if (cmdTaken) begin
      standbyCmd_q <= 1'b0;
      normalCmd_q <= 1'b0;
    end
  end

  // ==========================================================
  // Low-power state machine
  always_comb begin
    state_d = state_q;
    if (overrideStateEnable) begin
      state_d = lpsc_pkg::lpsc_state_t'(overrideStateValue);
    end else begin
      unique case (state_q)
        lpsc_pkg::ST_INIT: begin
          if (strapTaken_q) begin
            state_d = autoMode ? lpsc_pkg::ST_NORMAL : lpsc_pkg::ST_STANDBY;
          end
        end
        lpsc_pkg::ST_STANDBY: begin
          if (normalCmd_q) begin
            state_d = lpsc_pkg::ST_NORMAL;
          end else if (sleepRequest && sleepAllowed) begin
            state_d = lpsc_pkg::ST_SLEEP;
          end
        end
        lpsc_pkg::ST_NORMAL: begin
          if (standbyCmd_q) begin
            state_d = lpsc_pkg::ST_STANDBY;
          end
        end
        lpsc_pkg::ST_SLEEP: begin
          if (normalCmd_q) begin
            state_d = lpsc_pkg::ST_NORMAL;
          end else if (wakeEvent || standbyCmd_q) begin
            state_d = lpsc_pkg::ST_STANDBY;
          end
        end
        default: begin
          // Released from an unlisted forced code
          state_d = lpsc_pkg::ST_STANDBY;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= lpsc_pkg::ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      macPowerDown_q <= 1'b0;
    end else begin
      macPowerDown_q <= topConfig_q[lpsc_pkg::MAC_PD_EN_BIT] &&
                        (state_d == lpsc_pkg::ST_STANDBY || state_d == lpsc_pkg::ST_SLEEP);
    end
  end

  assign macInterfacePowerDown = macPowerDown_q;
  assign lineEnergyDetectEnable = lpConfigTwo_q[lpsc_pkg::LINE_ENERGY_DETECT_ENABLE_BIT];
  assign currentPowerState = state_q;

  // ==========================================================
  // Read data
  always_comb begin
    rdData = 32'h0000_0000;
    unique case (rdIdx)
      lpsc_pkg::IDX_TOP_CONFIG: rdData[15:0] = topConfig_q;
      lpsc_pkg::IDX_STATE_OVERRIDE: rdData[15:0] = stateOverride_q;
      lpsc_pkg::IDX_LP_CONFIG_TWO: rdData[15:0] = lpConfigTwo_q;
      lpsc_pkg::IDX_MODE_COMMAND: begin
        rdData[lpsc_pkg::CMD_STANDBY_BIT] = standbyCmd_q;
        rdData[lpsc_pkg::CMD_NORMAL_BIT] = normalCmd_q;
      end
      lpsc_pkg::IDX_STATE_STATUS: rdData[6:0] = state_q;
      default: rdData = 32'h0000_0000;
    endcase
  end

endmodule

// file: dv/lpsc_top_sva.sv
`timescale 1ns/1ps
module lpsc_top_sva (
  input wire logic clk,
  input wire logic rst,
  input wire lpsc_pkg::lpsc_axil_req_t axiReq,
  input wire lpsc_pkg::lpsc_axil_rsp_t axiRsp,
  input wire logic autoModeStrap,
  input wire logic sleepRequest,
  input wire logic lineEnergyDetected,
  input wire logic localWakeRequest,
  input wire logic lineEnergyDetectEnable,
  input wire logic macInterfacePowerDown,
  input wire logic [6:0] currentPowerState
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Register bus timing
  a_read_latency: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read answer not one cycle after address");
  a_read_hold: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read answer dropped or changed before taken");
  a_write_latency: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
    |-> ##2 axiRsp.bvalid) else $error("write answer not two cycles after transfer");
  a_write_refuse: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write accepted while response pending");
  a_read_refuse: assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read accepted while answer pending");
  a_upper_zero: assert property (axiRsp.rvalid |-> axiRsp.rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  // ==========================================================
  // Power state behaviour
  a_power_up_state: assert property ($fell(rst) |-> ##2
    currentPowerState == ($past(autoModeStrap, 2) ? 7'h04 : 7'h02)) else $error("wrong power-up state");
  a_macpd_lowpower: assert property (macInterfacePowerDown |->
    currentPowerState == 7'h02 || currentPowerState == 7'h06) else $error("mac power down outside low power");
  a_ed_after_write: assert property ($changed(lineEnergyDetectEnable) |->
    axiRsp.bvalid || $past(axiRsp.bvalid)) else $error("energy detect enable changed without write");
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  lpsc_pkg::lpsc_axil_req_t req = '0;
  lpsc_pkg::lpsc_axil_rsp_t rsp;
  logic autoModeStrap = 1'b1;
  logic sleepRequest = 1'b0;
  logic lineEnergyDetected = 1'b0;
  logic localWakeRequest = 1'b0;
  logic ledEn;
  logic macPd;
  logic [6:0] curSt;
  logic [31:0] rng = 32'h2CDC;
  logic [33:0] rdQ[$];
  logic [1:0] bQ[$];
  int miscompares = 0;
  int comparisons = 0;

  always #2.5 clk = ~clk;

  lpsc_top dut (.clk(clk), .rst(rst), .axiReq(req), .axiRsp(rsp), .autoModeStrap(autoModeStrap),
    .sleepRequest(sleepRequest), .lineEnergyDetected(lineEnergyDetected), .localWakeRequest(localWakeRequest),
    .lineEnergyDetectEnable(ledEn), .macInterfacePowerDown(macPd), .currentPowerState(curSt));

  // ==========================================================
  // Checking and reporting
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task complete_run;
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    if (!rst && rsp.rvalid && req.rready)
      cmp({rsp.rresp, rsp.rdata}, rdQ.size() != 0 ? rdQ.pop_front() : 'x);
    if (!rst && rsp.bvalid && req.bready)
      cmp({32'h0, rsp.bresp}, bQ.size() != 0 ? {32'h0, bQ.pop_front()} : 'x);
  end

  // ==========================================================
  // Register bus master: one write or one read per call
  task automatic xfer(input bit wrt, input logic [11:0] a, input logic [15:0] d,
                      input logic [1:0] e = lpsc_pkg::RESP_OKAY);
    int n;
    bit aw;
    bit w;
    bit ar;
    bit busy;
    @(posedge clk);
    aw = wrt;
    w = wrt;
    ar = !wrt;
    busy = 1'b1;
    if (wrt) begin
      req.awaddr <= a;
      req.wdata <= {16'h0000, d};
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      bQ.push_back(e);
    end else begin
      req.araddr <= a;
      rdQ.push_back({e, 16'h0000, d});
    end
    req.awvalid <= wrt;
    req.wvalid <= wrt;
    req.arvalid <= !wrt;
    for (n = 0; n < 64 && busy; n++) begin
      @(posedge clk);
      if (aw && rsp.awready) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
      if (ar && rsp.arready) begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
      // Late rready keeps the read answer waiting for two cycles
      if (!wrt && !ar && n >= 2 && !req.rready) begin
        req.rready <= 1'b1;
      end
      if (wrt ? rsp.bvalid && req.bready : rsp.rvalid && req.rready) begin
        busy = 1'b0;
        req.bready <= 1'b0;
        req.rready <= 1'b0;
      end
    end
    if (busy) begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic waitSt(input logic [6:0] exp);
    int n;
    for (n = 0; n < 64 && curSt !== exp; n++)
      @(posedge clk);
    cmp(curSt, exp);
    if (curSt !== exp) begin
      complete_run();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    waitSt(7'h04);
    xfer(0, 12'h604, 16'h0400);
    xfer(0, 12'h60C, 16'h0000);
    xfer(0, 12'h62C, 16'h0040);
    xfer(0, 12'h638, 16'h0004);
    xfer(0, 12'h700, 16'h0000, lpsc_pkg::RESP_SLVERR);
    xfer(1, 12'h700, 16'hFFFF, lpsc_pkg::RESP_SLVERR);
    repeat (4) begin
      rng = xs(rng);
      xfer(1, 12'h62C, rng[15:0]);
      xfer(0, 12'h62C, rng[15:0] & 16'h01FF);
      cmp(ledEn, rng[8]);
    end
    xfer(1, 12'h62C, 16'h0000);
    xfer(1, 12'h630, 16'h0010);
    waitSt(7'h02);
    xfer(0, 12'h630, 16'h0000);
    cmp(macPd, 1'b1);
    sleepRequest <= 1'b1;
    repeat (20) @(posedge clk);
    cmp(curSt, 7'h02);
    xfer(1, 12'h62C, 16'h0080);
    waitSt(7'h06);
    sleepRequest <= 1'b0;
    localWakeRequest <= 1'b1;
    waitSt(7'h02);
    localWakeRequest <= 1'b0;
    sleepRequest <= 1'b1;
    waitSt(7'h06);
    sleepRequest <= 1'b0;
    lineEnergyDetected <= 1'b1;
    repeat (8) @(posedge clk);
    cmp(curSt, 7'h06);
    xfer(1, 12'h62C, 16'h0180);
    cmp(ledEn, 1'b1);
    waitSt(7'h02);
    lineEnergyDetected <= 1'b0;
    xfer(1, 12'h630, 16'h0001);
    waitSt(7'h04);
    xfer(0, 12'h630, 16'h0000);
    cmp(macPd, 1'b0);
    xfer(1, 12'h60C, 16'h0082);
    waitSt(7'h02);
    xfer(1, 12'h630, 16'h0001);
    xfer(0, 12'h630, 16'h0001);
    xfer(0, 12'h638, 16'h0002);
    xfer(1, 12'h60C, 16'h0002);
    waitSt(7'h04);
    xfer(0, 12'h630, 16'h0000);
    xfer(1, 12'h604, 16'h0000);
    xfer(1, 12'h630, 16'h0010);
    waitSt(7'h02);
    repeat (2) @(posedge clk);
    cmp(macPd, 1'b0);
    // Second power-up with the strap low
    autoModeStrap <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    waitSt(7'h02);
    xfer(0, 12'h62C, 16'h0000);
    xfer(0, 12'h604, 16'h0400);
    cmp(macPd, 1'b1);
    cmp(ledEn, 1'b0);
    @(posedge clk);
    complete_run();
  end
endmodule

bind lpsc_top lpsc_top_sva chk (.clk(clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
  .autoModeStrap(autoModeStrap), .sleepRequest(sleepRequest), .lineEnergyDetected(lineEnergyDetected),
  .localWakeRequest(localWakeRequest), .lineEnergyDetectEnable(lineEnergyDetectEnable),
  .macInterfacePowerDown(macInterfacePowerDown), .currentPowerState(currentPowerState));
